/* File: hdl/imac_pkg.sv */
// shared constants and types for the integer multiply-accumulate block
package imac_pkg;

  // implementation style selection
  typedef enum {
    IMPL_AUTO,
    IMPL_FABRIC_LOGIC,
    IMPL_HARD_MACRO
  } imac_impl_type;

  // documented defaults
  localparam int OPERAND_WIDTH_DEF = 8;
  localparam int FABRIC_MAX_WIDTH = 8;
  localparam int MACRO_SMALL_MAX_WIDTH = 16;
  localparam int WIDE_OPERAND_WIDTH = 32;
  localparam int RESULT_LIMIT_SMALL = 48;
  localparam int RESULT_LIMIT_WIDE = 64;
  localparam int PIPE_STAGES_MAX_NORMAL = 2;
  localparam int PIPE_STAGES_MAX_WIDE = 3;

  // register byte offsets on the control bus
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_OFFSET = 8'h08;
  localparam logic [7:0] SNAP_LO_OFFSET = 8'h0C;
  localparam logic [7:0] SNAP_HI_OFFSET = 8'h10;

  // control register fields and reset value
  localparam int CTRL_COUNT_EN_BIT = 0;
  localparam int CTRL_SNAPSHOT_BIT = 1;
  localparam int CTRL_COUNT_CLR_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status register fields
  localparam int STATUS_WIDTH_LSB = 0;
  localparam int STATUS_ACC_BIT = 8;
  localparam int STATUS_INSTAGE_BIT = 9;
  localparam int STATUS_STAGES_LSB = 10;
  localparam int STATUS_MACRO_BIT = 12;
  localparam int STATUS_SIGNED_BIT = 13;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // hard macro is chosen above the fabric width limit in auto mode
  function automatic bit uses_macro(input imac_impl_type style, input int width);
    if (style == IMPL_AUTO)
      return width > FABRIC_MAX_WIDTH;
    return style == IMPL_HARD_MACRO;
  endfunction

  // default result width for a given configuration
  function automatic int default_result_width(input int width, input bit acc, input bit macro);
    if (width == WIDE_OPERAND_WIDTH)
      return RESULT_LIMIT_WIDE;
    if (acc && (macro || width > FABRIC_MAX_WIDTH))
      return RESULT_LIMIT_SMALL;
    return 2 * width;
  endfunction

endpackage

/* File: hdl/imac_multiply_accumulate.sv */
// integer multiplier with optional accumulator, pipeline stages and a control bus slave
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps

// How it works
// RL1: operands are operand width bits; 3 to 8, 16 or 32; default 8
// RL2: each operand signed when its setting is 0, unsigned when 1; default signed
// RL3: without accumulation the result is the product, delayed by the latency
// RL4: restart high stores the new product alone and presents it
// RL5: restart low adds the product to the stored sum and presents it
// RL6: restart is delayed like the operands; user raises it with first pair
// RL7: restart input is ignored when accumulation is off
// RL8: input stage on adds one operand register and one cycle
// RL9: each operand register has its own enable; ignored without input stage
// RL10: input registers share one synchronous active-low reset, ignored without stage
// RL11: pipe stages 0 to 2; 3 only for 32-bit accumulating configuration
// RL12: total latency equals pipe stages plus input stage setting
// RL13: one enable gates pipeline and accumulator; ignored with zero stages
// RL14: one synchronous active-low reset clears pipeline and accumulator; ignored with zero stages
// RL15: accumulator register exists apart from pipeline, works with zero stages
// RL16: result unsigned only when both operands unsigned, else signed
// RL17: wider result sign-extends signed values; overflow loses high bits
// RL18: plain product default twice operand width; max 48, or 64 for 32-bit
// RL19: hard macro accumulator up to 16-bit operands limited to 48 bits
// RL20: fabric and 32-bit accumulators are result width wide; 32-bit default 64
// RL21: style auto, fabric or hard macro; auto picks fabric up to 8 bits
// RL22: input stage, pipe stages and accumulation all default off
// RL23: disabled enable holds contents; asserted synchronous reset loads zero
module imac_multiply_accumulate #(
  parameter int OPERAND_WIDTH = imac_pkg::OPERAND_WIDTH_DEF,
  parameter bit UNSIGNED_A = 1'b0,
  parameter bit UNSIGNED_B = 1'b0,
  parameter bit ACCUMULATE = 1'b0,
  parameter bit INPUT_STAGE_ON = 1'b0,
  parameter int PIPE_STAGES = 0,
  parameter imac_pkg::imac_impl_type IMPL_STYLE = imac_pkg::IMPL_AUTO,
  parameter int RESULT_WIDTH = imac_pkg::default_result_width(OPERAND_WIDTH, ACCUMULATE,
    imac_pkg::uses_macro(IMPL_STYLE, OPERAND_WIDTH))
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // operands
  input wire logic [OPERAND_WIDTH-1:0] operand_a,
  input wire logic [OPERAND_WIDTH-1:0] operand_b,
  // input stage controls
  input wire logic input_stage_a_en,
  input wire logic input_stage_b_en,
  input wire logic input_stage_reset_n,
  // pipeline and accumulator controls
  input wire logic pipe_stage_en,
  input wire logic pipe_stage_reset_n,
  input wire logic accum_restart,
  // result
  output logic [RESULT_WIDTH-1:0] result,
  // control bus write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // control bus write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // control bus read
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // RL21: resolve implementation style
  localparam bit IS_MACRO = imac_pkg::uses_macro(IMPL_STYLE, OPERAND_WIDTH);
  localparam int PW = 2 * OPERAND_WIDTH;
  localparam bit RES_SIGNED = !(UNSIGNED_A && UNSIGNED_B);
  // RL11: an illegal count of three falls back to the normal maximum
  localparam bit WIDE_ACC = (OPERAND_WIDTH == imac_pkg::WIDE_OPERAND_WIDTH) && ACCUMULATE;
  localparam int PS_MAX = WIDE_ACC ? imac_pkg::PIPE_STAGES_MAX_WIDE : imac_pkg::PIPE_STAGES_MAX_NORMAL;
  localparam int PS = (PIPE_STAGES > PS_MAX) ? PS_MAX : ((PIPE_STAGES < 0) ? 0 : PIPE_STAGES);
  // RL18: width limits on the plain product
  localparam int PLAIN_LIMIT = (OPERAND_WIDTH == imac_pkg::WIDE_OPERAND_WIDTH) ?
    imac_pkg::RESULT_LIMIT_WIDE : imac_pkg::RESULT_LIMIT_SMALL;
  // RL19: hard-macro accumulator is capped; RL20: fabric and wide ones are not
  localparam bit ACC_CAPPED = IS_MACRO && (OPERAND_WIDTH <= imac_pkg::MACRO_SMALL_MAX_WIDTH);
  localparam int LIMIT = ACCUMULATE ? (ACC_CAPPED ? imac_pkg::RESULT_LIMIT_SMALL : RESULT_WIDTH) : PLAIN_LIMIT;
  localparam int AW = (RESULT_WIDTH > LIMIT) ? LIMIT : RESULT_WIDTH;
  localparam int EW = (AW > PW) ? AW : PW;
  // the accumulator register stands in for the last pipeline stage
  localparam int DS = (ACCUMULATE && PS > 0) ? PS - 1 : PS;

  // ---------------- input stage ----------------
  logic [OPERAND_WIDTH-1:0] in_a_reg;
  logic [OPERAND_WIDTH-1:0] in_b_reg;
  logic in_restart_reg;
  logic [OPERAND_WIDTH-1:0] op_a;
  logic [OPERAND_WIDTH-1:0] op_b;
  logic op_restart;

  generate
    if (INPUT_STAGE_ON)
    begin : g_in_stage
      // RL8: one operand register each; RL9: separate enables
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          in_a_reg <= '0;
        // RL10: shared synchronous clear
        else if (!input_stage_reset_n)
          in_a_reg <= '0;
        // RL23: hold while disabled
        else if (input_stage_a_en)
          in_a_reg <= operand_a;
      end

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          in_b_reg <= '0;
        else if (!input_stage_reset_n)
          in_b_reg <= '0;
        else if (input_stage_b_en)
          in_b_reg <= operand_b;
      end

      // RL6: restart travels with the operands, taken when either operand loads
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          in_restart_reg <= 1'b0;
        else if (!input_stage_reset_n)
          in_restart_reg <= 1'b0;
        else if (input_stage_a_en || input_stage_b_en)
          in_restart_reg <= accum_restart;
      end

      assign op_a = in_a_reg;
      assign op_b = in_b_reg;
      assign op_restart = in_restart_reg;
    end
    else
    begin : g_no_in_stage
      // RL9 RL10: enables and reset have no effect here
      assign in_a_reg = '0;
      assign in_b_reg = '0;
      assign in_restart_reg = 1'b0;
      assign op_a = operand_a;
      assign op_b = operand_b;
      assign op_restart = accum_restart;
    end
  endgenerate

  // ---------------- multiplier ----------------
  // RL2: extend each operand by one bit, sign or zero as configured
  logic signed [OPERAND_WIDTH:0] mul_a;
  logic signed [OPERAND_WIDTH:0] mul_b;
  logic signed [PW+1:0] mul_full;
  logic [PW-1:0] product;
  logic [EW-1:0] product_ext;
  logic [AW-1:0] product_aw;

  assign mul_a = {(!UNSIGNED_A) & op_a[OPERAND_WIDTH-1], op_a};
  assign mul_b = {(!UNSIGNED_B) & op_b[OPERAND_WIDTH-1], op_b};
  assign mul_full = mul_a * mul_b;
  // mixed signedness still fits twice the operand width
  assign product = mul_full[PW-1:0];
  // RL16 RL17: sign-extend only signed results, then drop excess high bits
  assign product_ext = RES_SIGNED ? EW'($signed(product)) : EW'(product);
  assign product_aw = product_ext[AW-1:0];

  // ---------------- pipeline ----------------
  logic [AW-1:0] stage_val [0:DS];
  logic stage_restart [0:DS];
  logic pipe_load;
  logic pipe_clear;

  // RL13 RL14: controls are only live when stages exist
  assign pipe_load = (PS == 0) || pipe_stage_en;
  assign pipe_clear = (PS != 0) && !pipe_stage_reset_n;

  assign stage_val[0] = product_aw;
  // RL7: restart is forced low when not accumulating
  assign stage_restart[0] = ACCUMULATE && op_restart;

  genvar gi;
  generate
    for (gi = 1; gi <= DS; gi++)
    begin : g_stage
      // RL12: each stage adds one cycle
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stage_val[gi] <= '0;
          stage_restart[gi] <= 1'b0;
        end
        // RL14: synchronous clear; RL23: loads zero
        else if (pipe_clear)
        begin
          stage_val[gi] <= '0;
          stage_restart[gi] <= 1'b0;
        end
        // RL13: shared enable
        else if (pipe_load)
        begin
          stage_val[gi] <= stage_val[gi-1];
          stage_restart[gi] <= stage_restart[gi-1];
        end
      end
    end
  endgenerate

  // ---------------- accumulator ----------------
  logic [AW-1:0] acc_reg;
  logic [AW-1:0] acc_next;
  logic [AW-1:0] core_result;
  logic result_update;

  // RL4: restart discards the old sum; RL5: otherwise add
  assign acc_next = stage_restart[DS] ? stage_val[DS] : AW'(acc_reg + stage_val[DS]);

  generate
    if (ACCUMULATE)
    begin : g_acc
      // RL15: the accumulator exists with or without pipeline stages
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          acc_reg <= '0;
        // RL14: cleared with the pipeline
        else if (pipe_clear)
          acc_reg <= '0;
        // RL13: gated with the pipeline
        else if (pipe_load)
          acc_reg <= acc_next;
      end
      // with no stages the sum is presented in the cycle it is formed, keeping latency exact
      assign core_result = (PS == 0) ? acc_next : acc_reg;
    end
    else
    begin : g_no_acc
      assign acc_reg = '0;
      // RL3: the delayed product
      assign core_result = stage_val[DS];
    end
  endgenerate

  assign result_update = pipe_load && !pipe_clear;
  // RL17: final widening keeps the result's sign
  assign result = RES_SIGNED ? RESULT_WIDTH'($signed(core_result)) : RESULT_WIDTH'(core_result);

  // ---------------- control bus slave ----------------
  logic aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] count_reg;
  logic [63:0] snap_reg;
  logic snap_req_reg;

  logic aw_take;
  logic w_take;
  logic do_write;
  logic ar_take;
  logic wr_ctrl;
  logic wr_known;
  logic rd_known;
  logic [31:0] rd_value;
  logic [31:0] status_word;
  logic [63:0] result_wide;
  logic count_clear;
  logic count_event;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  // address and data may arrive in either order
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

  assign wr_ctrl = do_write && (aw_addr_reg == imac_pkg::CTRL_OFFSET) && w_strb_reg[0];
  assign wr_known = (aw_addr_reg == imac_pkg::CTRL_OFFSET) || (aw_addr_reg == imac_pkg::STATUS_OFFSET) ||
    (aw_addr_reg == imac_pkg::COUNT_OFFSET) || (aw_addr_reg == imac_pkg::SNAP_LO_OFFSET) ||
    (aw_addr_reg == imac_pkg::SNAP_HI_OFFSET);

  assign status_word = (32'(OPERAND_WIDTH) << imac_pkg::STATUS_WIDTH_LSB) |
    (32'(ACCUMULATE) << imac_pkg::STATUS_ACC_BIT) |
    (32'(INPUT_STAGE_ON) << imac_pkg::STATUS_INSTAGE_BIT) |
    (32'(PS) << imac_pkg::STATUS_STAGES_LSB) |
    (32'(IS_MACRO) << imac_pkg::STATUS_MACRO_BIT) |
    (32'(RES_SIGNED) << imac_pkg::STATUS_SIGNED_BIT);

  assign rd_known = (s_axi_araddr == imac_pkg::CTRL_OFFSET) || (s_axi_araddr == imac_pkg::STATUS_OFFSET) ||
    (s_axi_araddr == imac_pkg::COUNT_OFFSET) || (s_axi_araddr == imac_pkg::SNAP_LO_OFFSET) ||
    (s_axi_araddr == imac_pkg::SNAP_HI_OFFSET);
  assign rd_value = (s_axi_araddr == imac_pkg::CTRL_OFFSET) ? ctrl_reg :
    (s_axi_araddr == imac_pkg::STATUS_OFFSET) ? status_word :
    (s_axi_araddr == imac_pkg::COUNT_OFFSET) ? count_reg :
    (s_axi_araddr == imac_pkg::SNAP_LO_OFFSET) ? snap_reg[31:0] :
    (s_axi_araddr == imac_pkg::SNAP_HI_OFFSET) ? snap_reg[63:32] : 32'h0000_0000;

  // snapshot sees the result sign-extended (signed) or zero-extended (unsigned) to 64 bits so software needs no width logic
  assign result_wide = RES_SIGNED ? 64'($signed(core_result)) : 64'(core_result);
  assign count_clear = wr_ctrl && w_data_reg[imac_pkg::CTRL_COUNT_CLR_BIT];
  assign count_event = ctrl_reg[imac_pkg::CTRL_COUNT_EN_BIT] && result_update;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end
    else if (aw_take)
    begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (w_take)
    begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
    else if (do_write)
      w_held_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= imac_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_known ? imac_pkg::RESP_OKAY : imac_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= imac_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_value;
      rresp_reg <= rd_known ? imac_pkg::RESP_OKAY : imac_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // only the count enable is stored; snapshot and clear act as strobes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_reg <= imac_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl_reg <= {31'h0000_0000, w_data_reg[imac_pkg::CTRL_COUNT_EN_BIT]};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      snap_req_reg <= 1'b0;
    else
      snap_req_reg <= wr_ctrl && w_data_reg[imac_pkg::CTRL_SNAPSHOT_BIT];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      snap_reg <= 64'h0000_0000_0000_0000;
    else if (snap_req_reg)
      snap_reg <= result_wide;
  end

  // an update in the clearing cycle is kept, so the count restarts at one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= 32'h0000_0000;
    else if (count_clear)
      count_reg <= {31'h0000_0000, count_event};
    else if (count_event)
      count_reg <= count_reg + 32'h0000_0001;
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule

/* File: tb/imac_mac_properties.sv */
// port-level checks for the multiply-accumulate block
`timescale 1ns/100ps
module imac_mac_properties #(
  parameter int OPERAND_WIDTH = 8,
  parameter int RESULT_WIDTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // datapath
  input wire logic [OPERAND_WIDTH-1:0] operand_a,
  input wire logic [OPERAND_WIDTH-1:0] operand_b,
  input wire logic input_stage_a_en,
  input wire logic input_stage_b_en,
  input wire logic input_stage_reset_n,
  input wire logic pipe_stage_en,
  input wire logic pipe_stage_reset_n,
  input wire logic accum_restart,
  input wire logic [RESULT_WIDTH-1:0] result,
  // control bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // written for signed operands with input stage and one accumulating stage
  function automatic logic [RESULT_WIDTH-1:0] prod(input logic [OPERAND_WIDTH-1:0] x,
    input logic [OPERAND_WIDTH-1:0] y);
    logic signed [RESULT_WIDTH-1:0] sx;
    logic signed [RESULT_WIDTH-1:0] sy;
    sx = $signed(x);
    sy = $signed(y);
    return sx * sy;
  endfunction

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_pair(logic rs);
    input_stage_a_en && input_stage_b_en && input_stage_reset_n && accum_restart == rs;
  endsequence
  sequence s_pipe_go;
    pipe_stage_en && pipe_stage_reset_n;
  endsequence

  property p_restart;
    s_pair(1'b1) ##1 s_pipe_go |=> result == prod($past(operand_a, 2), $past(operand_b, 2));
  endproperty
  a_restart: assert property (p_restart)
    else $error("new sum does not start at the product");
  property p_accum;
    s_pair(1'b0) ##1 s_pipe_go |=> result == $past(result) + prod($past(operand_a, 2), $past(operand_b, 2));
  endproperty
  a_accum: assert property (p_accum)
    else $error("running sum is wrong");
  property p_pipe_hold;
    !pipe_stage_en && pipe_stage_reset_n |=> $stable(result);
  endproperty
  a_pipe_hold: assert property (p_pipe_hold)
    else $error("result moved while pipeline disabled");
  property p_pipe_clear;
    !pipe_stage_reset_n |=> result == '0;
  endproperty
  a_pipe_clear: assert property (p_pipe_clear)
    else $error("pipeline clear did not zero result");
  property p_in_clear;
    !input_stage_reset_n ##1 s_pipe_go |=> $stable(result);
  endproperty
  a_in_clear: assert property (p_in_clear)
    else $error("cleared input stage still fed a product");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
  property p_ar_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar_answer: assert property (p_ar_answer)
    else $error("read not answered in one cycle");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("write accepted while response pending");
endmodule

bind imac_multiply_accumulate imac_mac_properties #(.OPERAND_WIDTH(OPERAND_WIDTH), .RESULT_WIDTH(RESULT_WIDTH))
  imac_mac_properties_i (.clk, .rst_n, .operand_a, .operand_b, .input_stage_a_en, .input_stage_b_en,
  .input_stage_reset_n, .pipe_stage_en, .pipe_stage_reset_n, .accum_restart, .result, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready);

/* File: tb/imac_user_model.sv */
// user logic model that feeds operands and controls
`timescale 1ns/100ps
module imac_user_model #(
  parameter int OW = 8
) (
  // clock, reset and run request
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  // towards the block
  output logic [OW-1:0] operand_a,
  output logic [OW-1:0] operand_b,
  output logic input_stage_a_en,
  output logic input_stage_b_en,
  output logic input_stage_reset_n,
  output logic pipe_stage_en,
  output logic pipe_stage_reset_n,
  output logic accum_restart
);
  int k;
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      k <= 0;
      {operand_a, operand_b, input_stage_a_en, input_stage_b_en} <= '0;
      {input_stage_reset_n, pipe_stage_en, pipe_stage_reset_n, accum_restart} <= '0;
    end
    else if (run)
    begin
      k <= k + 1;
      operand_a <= (k % 8 == 0) ? OW'(1) << (OW - 1) : OW'(k * 37 + 5);
      operand_b <= (k % 8 == 1) ? ~(OW'(1) << (OW - 1)) : OW'(k * 13 + 200);
      accum_restart <= (k % 10 == 0);
      input_stage_a_en <= (k % 7 != 3);
      input_stage_b_en <= (k % 9 != 5);
      input_stage_reset_n <= (k % 23 != 11);
      pipe_stage_en <= (k % 6 != 4);
      pipe_stage_reset_n <= (k % 31 != 17);
    end
    else
    begin
      // idle operands toggle so a stale value cannot pass for a held one
      operand_a <= ~operand_a;
      operand_b <= ~operand_b;
      {input_stage_a_en, input_stage_b_en, pipe_stage_en} <= '0;
      {input_stage_reset_n, pipe_stage_reset_n} <= 2'h3;
    end
endmodule

/* File: tb/imac_multiply_accumulate_test.sv */
// self-checking bench for the multiply-accumulate block
`timescale 1ns/100ps
module imac_multiply_accumulate_test;
  localparam int OW = 8;
  localparam int RW = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0;
  logic [OW-1:0] operand_a, operand_b, ra, rb;
  logic input_stage_a_en, input_stage_b_en, input_stage_reset_n, rr;
  logic pipe_stage_en, pipe_stage_reset_n, accum_restart;
  logic [RW-1:0] result, ref_acc;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int err_count = 0;
  int checks = 0;

  always #10 clk = ~clk;

  imac_user_model #(.OW(OW)) imac_user_model_i (.clk, .rst_n, .run, .operand_a, .operand_b, .input_stage_a_en,
    .input_stage_b_en, .input_stage_reset_n, .pipe_stage_en, .pipe_stage_reset_n, .accum_restart);

  imac_multiply_accumulate #(.OPERAND_WIDTH(OW), .ACCUMULATE(1'b1), .INPUT_STAGE_ON(1'b1), .PIPE_STAGES(1),
    .RESULT_WIDTH(RW)) imac_multiply_accumulate_i (.clk, .rst_n, .operand_a, .operand_b, .input_stage_a_en,
    .input_stage_b_en, .input_stage_reset_n, .pipe_stage_en, .pipe_stage_reset_n, .accum_restart, .result,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  function automatic logic [RW-1:0] prod(input logic [OW-1:0] x, input logic [OW-1:0] y);
    logic signed [RW-1:0] sx;
    logic signed [RW-1:0] sy;
    sx = $signed(x);
    sy = $signed(y);
    return sx * sy;
  endfunction

  // expected accumulator: input stage, then one accumulating stage
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      {ra, rb, rr, ref_acc} <= '0;
    else
    begin
      if (!input_stage_reset_n)
        {ra, rb, rr} <= '0;
      else
      begin
        ra <= input_stage_a_en ? operand_a : ra;
        rb <= input_stage_b_en ? operand_b : rb;
        rr <= (input_stage_a_en || input_stage_b_en) ? accum_restart : rr;
      end
      if (!pipe_stage_reset_n)
        ref_acc <= '0;
      else if (pipe_stage_en)
        ref_acc <= rr ? prod(ra, rb) : ref_acc + prod(ra, rb);
    end

  task cmp_res(input logic [RW-1:0] exp, input logic [RW-1:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task cmp_bus(input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  always @(negedge clk)
    cmp_res(ref_acc, result);

  task axi_write(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
    int n;
    logic aw_hs, w_hs, b_hs;
    logic [1:0] got;
    n = 0;
    b_hs = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!b_hs && n < 100)
    begin
      @(negedge clk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bready && s_axi_bvalid;
      got = s_axi_bresp;
      @(posedge clk);
      if (aw_hs)
        s_axi_awvalid <= 1'b0;
      if (w_hs)
        s_axi_wvalid <= 1'b0;
      s_axi_bready <= !b_hs;
      n++;
    end
    if (!b_hs)
      err_count++;
    cmp_bus({30'h0, resp}, {30'h0, got});
  endtask

  task axi_read(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
    int n;
    logic ar_hs, r_hs;
    logic [31:0] got;
    logic [1:0] gr;
    n = 0;
    r_hs = 1'b0;
    @(posedge clk);
    s_axi_araddr <= addr;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!r_hs && n < 100)
    begin
      @(negedge clk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rready && s_axi_rvalid;
      got = s_axi_rdata;
      gr = s_axi_rresp;
      @(posedge clk);
      if (ar_hs)
        s_axi_arvalid <= 1'b0;
      s_axi_rready <= !r_hs;
      n++;
    end
    if (!r_hs)
      err_count++;
    cmp_bus(data, got);
    cmp_bus({30'h0, resp}, {30'h0, gr});
  endtask

  task end_sim;
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    err_count++;
    end_sim;
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // width 8, accumulating, input stage, one stage, fabric, signed
    axi_read(imac_pkg::STATUS_OFFSET, 32'h0000_2708, imac_pkg::RESP_OKAY);
    axi_read(imac_pkg::CTRL_OFFSET, imac_pkg::CTRL_RESET, imac_pkg::RESP_OKAY);
    axi_write(imac_pkg::CTRL_OFFSET, 32'h0000_0001, imac_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'h2;
    axi_write(imac_pkg::CTRL_OFFSET, 32'h0, imac_pkg::RESP_OKAY);
    axi_read(imac_pkg::CTRL_OFFSET, 32'h0000_0001, imac_pkg::RESP_OKAY);
    axi_write(imac_pkg::STATUS_OFFSET, 32'hFFFF_FFFF, imac_pkg::RESP_OKAY);
    axi_read(imac_pkg::STATUS_OFFSET, 32'h0000_2708, imac_pkg::RESP_OKAY);
    axi_write(8'h20, 32'h0000_0005, imac_pkg::RESP_SLVERR);
    axi_read(8'h20, 32'h0000_0000, imac_pkg::RESP_SLVERR);
    run <= 1'b1;
    repeat (150) @(posedge clk);
    run <= 1'b0;
    repeat (6) @(posedge clk);
    // reset in mid-run, then resume
    run <= 1'b1;
    repeat (40) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (80) @(posedge clk);
    end_sim;
  end
endmodule
